// >>> src/rxp_top.v
// radio exchange-memory fault flag, base register and probe multiplexer
// assumes the link-layer controller and probe sources share i_ref_clk,
// so their inputs are used without synchronisers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rxp_top #(
  parameter PAGES = 32,
  parameter PG_W  = 5,
  parameter NGRP  = 64
) (
  input  wire              i_ref_clk,
  input  wire              i_reset_n,
  // AXI4-Lite slave
  input  wire [31:0]       i_s_axi_awaddr,
  input  wire              i_s_axi_awvalid,
  output wire              o_s_axi_awready,
  input  wire [31:0]       i_s_axi_wdata,
  input  wire [3:0]        i_s_axi_wstrb,
  input  wire              i_s_axi_wvalid,
  output wire              o_s_axi_wready,
  output wire [1:0]        o_s_axi_bresp,
  output wire              o_s_axi_bvalid,
  input  wire              i_s_axi_bready,
  input  wire [31:0]       i_s_axi_araddr,
  input  wire              i_s_axi_arvalid,
  output wire              o_s_axi_arready,
  output wire [31:0]       o_s_axi_rdata,
  output wire [1:0]        o_s_axi_rresp,
  output wire              o_s_axi_rvalid,
  input  wire              i_s_axi_rready,
  // link-layer controller exchange-memory accesses
  input  wire              i_xmem_access_valid,
  input  wire [PG_W-1:0]   i_xmem_access_page,
  input  wire [PAGES-1:0]  i_xmem_page_map,
  // probe sources
  input  wire [23:0]       i_probe_low_sources,
  input  wire [NGRP*8-1:0] i_probe_groups,
  // outputs
  output reg               o_radio_error_interrupt,
  output reg               o_irq,
  output reg  [7:0]        o_probe_port,
  output reg  [6:0]        o_xmem_base_field
);
`include "rxp_regs.vh"

  // ==========================================================
  // declarations
  wire        wr_en;
  wire [31:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        rd_en;
  wire [31:0] wmask;
  wire [31:0] wbits;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;

  wire        wr_misc;
  wire        wr_base;
  wire        wr_lsu;
  wire        wr_bsi;
  wire        wr_istat;
  wire        wr_imask;

  reg         fault_flag_q;
  reg         fault_flag_d;
  reg         fault_mask_q;
  reg  [6:0]  base_q;
  reg  [31:0] lsu_q;
  reg  [31:0] bsi_q;
  reg         irq_stat_q;
  reg         irq_stat_d;
  reg         irq_mask_q;

  wire        fault_evt;
  wire [47:0] lane_sources;
  wire [7:0]  lane_enables;
  wire [7:0]  lane_bits;

  // ==========================================================
  // bus slave
  rxp_axil_slave u_bus (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_awaddr  (i_s_axi_awaddr),
    .i_awvalid (i_s_axi_awvalid),
    .o_awready (o_s_axi_awready),
    .i_wdata   (i_s_axi_wdata),
    .i_wstrb   (i_s_axi_wstrb),
    .i_wvalid  (i_s_axi_wvalid),
    .o_wready  (o_s_axi_wready),
    .o_bresp   (o_s_axi_bresp),
    .o_bvalid  (o_s_axi_bvalid),
    .i_bready  (i_s_axi_bready),
    .i_arvalid (i_s_axi_arvalid),
    .o_arready (o_s_axi_arready),
    .o_rdata   (o_s_axi_rdata),
    .o_rresp   (o_s_axi_rresp),
    .o_rvalid  (o_s_axi_rvalid),
    .i_rready  (i_s_axi_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  // ==========================================================
  // byte-lane write mask
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_wmask
      assign wmask[b*8 +: 8] = {8{wr_strb[b]}};
    end
  endgenerate

  // only the enabled byte lanes carry ones for write-one fields
  assign wbits = wr_data & wmask;

  // ==========================================================
  // write decode, low two address bits ignored
  assign wr_misc  = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_MISC_ADDR);
  assign wr_base  = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_BASE_ADDR);
  assign wr_lsu   = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_LSU_ADDR);
  assign wr_bsi   = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_BSI_ADDR);
  assign wr_istat = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_IRQ_STAT_ADDR);
  assign wr_imask = wr_en && ({wr_addr[31:2], 2'h0} == `RXP_IRQ_MASK_ADDR);

  always @*
  begin
    wr_err = !(wr_misc || wr_base || wr_lsu || wr_bsi || wr_istat || wr_imask);
  end

  // ==========================================================
  // exchange-memory fault detection
  // a page whose map bit is low is not covered by the current mapping
  assign fault_evt = i_xmem_access_valid && !i_xmem_page_map[i_xmem_access_page];

  // the hardware set wins over a same-cycle acknowledge so no fault is lost
  always @*
  begin
    fault_flag_d = fault_flag_q;
    if (wr_misc && wbits[`RXP_MISC_ACK_BIT])
      fault_flag_d = 1'b0;
    if (fault_evt)
      fault_flag_d = 1'b1;
  end

  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_istat && wbits[`RXP_IRQ_FAULT_BIT])
      irq_stat_d = 1'b0;
    if (fault_evt)
      irq_stat_d = 1'b1;
  end

  // ==========================================================
  // event flags, set by hardware and cleared by software
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      fault_flag_q <= 1'b0;
      irq_stat_q   <= `RXP_IRQ_RESET;
    end
    else
    begin
      fault_flag_q <= fault_flag_d;
      irq_stat_q   <= irq_stat_d;
    end
  end

  // ==========================================================
  // software control registers
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      fault_mask_q <= `RXP_MISC_MASK_RESET;
      base_q       <= `RXP_BASE_RESET;
      lsu_q        <= `RXP_LSU_RESET;
      bsi_q        <= `RXP_BSI_RESET;
      irq_mask_q   <= `RXP_IRQ_RESET;
    end
    else
    begin
      // the flag bit itself ignores writes; only the ack bit acts
      if (wr_misc && wmask[`RXP_MISC_MASK_BIT])
        fault_mask_q <= wr_data[`RXP_MISC_MASK_BIT];
      if (wr_base)
        base_q <= (base_q & ~wmask[`RXP_BASE_MSB:`RXP_BASE_LSB])
                | wbits[`RXP_BASE_MSB:`RXP_BASE_LSB];
      if (wr_lsu)
        lsu_q <= ((lsu_q & ~wmask) | wbits) & `RXP_LSU_RW_MASK;
      if (wr_bsi)
        bsi_q <= (bsi_q & ~wmask) | wbits;
      if (wr_imask && wmask[`RXP_IRQ_FAULT_BIT])
        irq_mask_q <= wr_data[`RXP_IRQ_FAULT_BIT];
    end
  end

  // ==========================================================
  // read decode; unused and reserved bits read zero
  always @*
  begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    case ({i_s_axi_araddr[31:2], 2'h0})
      `RXP_MISC_ADDR:
      begin
        // the acknowledge bit is never stored, so it reads zero
        rd_data[`RXP_MISC_MASK_BIT] = fault_mask_q;
        rd_data[`RXP_MISC_FLAG_BIT] = fault_flag_q;
      end
      `RXP_BASE_ADDR:
        rd_data[`RXP_BASE_MSB:`RXP_BASE_LSB] = base_q;
      `RXP_LSU_ADDR:
        rd_data = lsu_q;
      `RXP_BSI_ADDR:
        rd_data = bsi_q;
      `RXP_IRQ_STAT_ADDR:
        rd_data[`RXP_IRQ_FAULT_BIT] = irq_stat_q;
      `RXP_IRQ_MASK_ADDR:
        rd_data[`RXP_IRQ_FAULT_BIT] = irq_mask_q;
      default:
        rd_err = 1'b1;
    endcase
  end

  // ==========================================================
  // probe lane controls
  // lanes zero to three come from a companion register and have no enable
  assign lane_sources[23:0] = i_probe_low_sources;
  assign lane_enables[3:0]  = 4'hf;

  genvar n;
  generate
    for (n = `RXP_LOW_LANES; n < `RXP_LANES; n = n + 1)
    begin : g_upper
      localparam integer FB = (n - `RXP_LOW_LANES) * `RXP_LSU_STRIDE;
      assign lane_sources[n*`RXP_SRC_W +: `RXP_SRC_W] = lsu_q[FB +: `RXP_SRC_W];
      assign lane_enables[n] = lsu_q[FB + `RXP_LSU_EN_POS];
    end
  endgenerate

  generate
    for (n = 0; n < `RXP_LANES; n = n + 1)
    begin : g_lane
      rxp_probe_lane #(
        .NGRP (NGRP)
      ) u_lane (
        .i_groups   (i_probe_groups),
        .i_source   (lane_sources[n*`RXP_SRC_W +: `RXP_SRC_W]),
        .i_enable   (lane_enables[n]),
        .i_bit_pick (bsi_q[n*`RXP_BSI_STRIDE +: `RXP_PICK_W]),
        .i_invert   (bsi_q[n*`RXP_BSI_STRIDE + `RXP_BSI_INV_POS]),
        .o_bit      (lane_bits[n])
      );
    end
  endgenerate

  // ==========================================================
  // registered outputs
  // one cycle of latency buys glitch-free pins at the cost of a lag
  // error interrupt is a level for as long as flag and mask are both set
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      o_radio_error_interrupt <= 1'b0;
    else
      o_radio_error_interrupt <= fault_flag_q && fault_mask_q;
  end

  // event interrupt from the own status and mask pair
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      o_irq <= 1'b0;
    else
      o_irq <= irq_stat_q && irq_mask_q;
  end

  // probe port, one bit per lane
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      o_probe_port <= 8'h00;
    else
      o_probe_port <= lane_bits;
  end

  // base field copy for the downstream address decoder
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
      o_xmem_base_field <= `RXP_BASE_RESET;
    else
      o_xmem_base_field <= base_q;
  end
endmodule // rxp_top

// >>> inc/rxp_regs.vh
// register offsets, field positions, reset values and codes for the
// radio exchange-memory fault and probe multiplexer block
// assumes a 32-bit AXI4-Lite byte address and aligned word accesses
`ifndef RXP_REGS_VH
`define RXP_REGS_VH

// ==========================================================
// register byte addresses
`define RXP_MISC_ADDR        32'h40000200
`define RXP_BASE_ADDR        32'h40000208
`define RXP_LSU_ADDR         32'h4000020c
`define RXP_BSI_ADDR         32'h40000210
`define RXP_IRQ_STAT_ADDR    32'h40000214
`define RXP_IRQ_MASK_ADDR    32'h40000218

// ==========================================================
// radio_misc_control fields
`define RXP_MISC_FLAG_BIT    0
`define RXP_MISC_ACK_BIT     1
`define RXP_MISC_MASK_BIT    2
`define RXP_MISC_MASK_RESET  1'h1

// ==========================================================
// xmem_base_address fields
`define RXP_BASE_LSB         10
`define RXP_BASE_MSB         16
`define RXP_BASE_RESET       7'h00

// ==========================================================
// probe register layouts
`define RXP_LSU_RW_MASK      32'hbfbfbfbf
`define RXP_LSU_RESET        32'h00000000
`define RXP_LSU_STRIDE       8
`define RXP_LSU_EN_POS       7
`define RXP_BSI_RESET        32'h00000000
`define RXP_BSI_STRIDE       4
`define RXP_BSI_INV_POS      3
`define RXP_SRC_W            6
`define RXP_PICK_W           3
`define RXP_LANES            8
`define RXP_LOW_LANES        4

// ==========================================================
// interrupt status layout and bus answers
`define RXP_IRQ_FAULT_BIT    0
`define RXP_IRQ_W            1
`define RXP_IRQ_RESET        1'h0
`define RXP_RESP_OKAY        2'h0
`define RXP_RESP_SLVERR      2'h2

`endif

// >>> src/rxp_probe_lane.v
// one diagnostic lane: source group select, enable, bit pick, invert
// assumes the group bus packs eight bits per group, group 0 lowest
`timescale 1ns/1ps
module rxp_probe_lane #(
  parameter NGRP = 64
) (
  input  wire [NGRP*8-1:0] i_groups,
  input  wire [5:0]        i_source,
  input  wire              i_enable,
  input  wire [2:0]        i_bit_pick,
  input  wire              i_invert,
  output wire              o_bit
);
  wire [8:0] base_idx;
  wire [7:0] word;

  assign base_idx = {i_source, 3'h0};
  // a disabled lane presents an all-zero word
  assign word  = i_enable ? i_groups[base_idx +: 8] : 8'h00;
  assign o_bit = word[i_bit_pick] ^ i_invert;
endmodule // rxp_probe_lane

// >>> src/rxp_axil_slave.v
// AXI4-Lite handshake engine: one write and one read in flight
// assumes the parent decodes addresses and supplies read data
// combinationally from the read address
`timescale 1ns/1ps
module rxp_axil_slave (
  input  wire        i_ref_clk,
  input  wire        i_reset_n,
  input  wire [31:0] i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output wire        o_wr_en,
  output reg  [31:0] o_wr_addr,
  output reg  [31:0] o_wr_data,
  output reg  [3:0]  o_wr_strb,
  input  wire        i_wr_err,
  output wire        o_rd_en,
  input  wire [31:0] i_rd_data,
  input  wire        i_rd_err
);
`include "rxp_regs.vh"

  // ready drops once a beat is held, so a held beat is !ready
  assign o_wr_en = !o_awready && !o_wready && !o_bvalid;
  assign o_rd_en = i_arvalid && o_arready;

  // ==========================================================
  // write channels
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RXP_RESP_OKAY;
      o_wr_addr <= 32'h00000000;
      o_wr_data <= 32'h00000000;
      o_wr_strb <= 4'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        o_awready <= 1'b0;
        o_wr_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        o_wready  <= 1'b0;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (o_wr_en)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= i_wr_err ? `RXP_RESP_SLVERR : `RXP_RESP_OKAY;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read channels
  always @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `RXP_RESP_OKAY;
    end
    else if (o_rd_en)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= i_rd_data;
      o_rresp   <= i_rd_err ? `RXP_RESP_SLVERR : `RXP_RESP_OKAY;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule // rxp_axil_slave

// >>> test/rxp_properties.sv
// checker: fault flag, interrupts, base and probe port against shadowed registers
// assumes aligned full-strobe bus writes, as the bench issues them
`timescale 1ns/1ps
`include "rxp_regs.vh"
module rxp_properties #(
  parameter PAGES = 32,
  parameter PG_W  = 5,
  parameter NGRP  = 64
) (
  input wire              i_ref_clk,
  input wire              i_reset_n,
  input wire [31:0]       i_s_axi_awaddr,
  input wire              i_s_axi_awvalid,
  input wire              o_s_axi_awready,
  input wire [31:0]       i_s_axi_wdata,
  input wire              i_s_axi_wvalid,
  input wire              o_s_axi_wready,
  input wire [1:0]        o_s_axi_bresp,
  input wire              o_s_axi_bvalid,
  input wire [31:0]       i_s_axi_araddr,
  input wire              i_s_axi_arvalid,
  input wire              o_s_axi_arready,
  input wire [31:0]       o_s_axi_rdata,
  input wire              o_s_axi_rvalid,
  input wire              i_xmem_access_valid,
  input wire [PG_W-1:0]   i_xmem_access_page,
  input wire [PAGES-1:0]  i_xmem_page_map,
  input wire [23:0]       i_probe_low_sources,
  input wire [NGRP*8-1:0] i_probe_groups,
  input wire              o_radio_error_interrupt,
  input wire              o_irq,
  input wire [7:0]        o_probe_port,
  input wire [6:0]        o_xmem_base_field
);
  // ==========================================================
  // shadow registers, one cycle behind the real ones, as the outputs are
  reg [31:0]       awa_q, wd_q, ara_q, lsu_q, bsi_q;
  reg [6:0]        base_q;
  reg              bv_q, ev_q, flag_q, mask_q, ist_q, imk_q;
  reg [NGRP*8-1:0] grp_q;
  reg [23:0]       low_q;
  reg [7:0]        exp_c, w_c;
  integer          n;
  wire ev = i_xmem_access_valid && !i_xmem_page_map[i_xmem_access_page];
  wire wb = o_s_axi_bvalid && !bv_q && o_s_axi_bresp == `RXP_RESP_OKAY;
  wire wm = wb && awa_q == `RXP_MISC_ADDR;
  wire ws = wb && awa_q == `RXP_IRQ_STAT_ADDR;

  always @(posedge i_ref_clk)
  begin
    grp_q <= i_probe_groups;
    low_q <= i_probe_low_sources;
    bv_q  <= o_s_axi_bvalid;
    if (i_s_axi_awvalid && o_s_axi_awready) awa_q <= i_s_axi_awaddr;
    if (i_s_axi_wvalid && o_s_axi_wready) wd_q <= i_s_axi_wdata;
    if (i_s_axi_arvalid && o_s_axi_arready) ara_q <= i_s_axi_araddr;
    if (!i_reset_n)
    begin
      {ev_q, flag_q, ist_q, imk_q, base_q, lsu_q, bsi_q} <= 0;
      mask_q <= 1'b1;
    end
    else
    begin
      ev_q   <= ev;
      // a new fault wins over a same-cycle acknowledge
      flag_q <= ev_q | (flag_q & ~(wm & wd_q[1]));
      ist_q  <= ev_q | (ist_q & ~(ws & wd_q[0]));
      if (wm) mask_q <= wd_q[2];
      if (wb && awa_q == `RXP_IRQ_MASK_ADDR) imk_q <= wd_q[0];
      if (wb && awa_q == `RXP_BASE_ADDR) base_q <= wd_q[16:10];
      if (wb && awa_q == `RXP_LSU_ADDR) lsu_q <= wd_q & `RXP_LSU_RW_MASK;
      if (wb && awa_q == `RXP_BSI_ADDR) bsi_q <= wd_q;
    end
  end

  always @*
  begin
    exp_c = 8'h00;
    for (n = 0; n < 8; n = n + 1)
    begin
      w_c = 8'h00;
      if (n < 4) w_c = grp_q[low_q[6*n +: 6]*8 +: 8];
      else if (lsu_q[8*n-25]) w_c = grp_q[lsu_q[8*n-32 +: 6]*8 +: 8];
      exp_c[n] = w_c[bsi_q[4*n +: 3]] ^ bsi_q[4*n+3];
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  AST_ERR_IRQ: assert property (o_radio_error_interrupt == (flag_q & mask_q))
    else $error("error interrupt differs from flag and mask");
  AST_FAULT_SETS: assert property (ev |-> ##2 (o_radio_error_interrupt || !mask_q))
    else $error("unmapped access did not raise the error interrupt");
  AST_EVT_IRQ: assert property (o_irq == (ist_q & imk_q))
    else $error("event interrupt differs from status and mask");
  AST_MISC_READ: assert property ($rose(o_s_axi_rvalid) && ara_q == `RXP_MISC_ADDR
    |-> o_s_axi_rdata[2:0] == {mask_q, 1'b0, flag_q})
    else $error("misc control read value wrong");
  AST_BASE_READ: assert property ($rose(o_s_axi_rvalid) && ara_q == `RXP_BASE_ADDR
    |-> o_s_axi_rdata == {15'h0000, base_q, 10'h000})
    else $error("base register read value wrong");
  AST_BASE_OUT: assert property (o_xmem_base_field == base_q)
    else $error("base field output wrong");
  AST_LANE_OFF: assert property (!lsu_q[31] |-> o_probe_port[7] == bsi_q[31])
    else $error("disabled lane not forced to zero");
  // on the first edge after release the port still holds its reset value
  AST_PROBE_MATCH: assert property ($past(i_reset_n)
    |-> o_probe_port == exp_c)
    else $error("probe port differs from selection");
  AST_PROBE_RESET: assert property ($rose(i_reset_n) |-> o_probe_port == 8'h00)
    else $error("probe port not zero after reset");
  cover property (ev);
  cover property ($rose(o_irq));
  cover property (lsu_q[31] && o_probe_port[7]);
endmodule // rxp_properties

bind rxp_top rxp_properties #(.PAGES(PAGES), .PG_W(PG_W), .NGRP(NGRP)) u_props (.*);

// >>> test/rxp_link_model.sv
// link-layer controller and probe source stand-in
// drives accesses and probe groups just after rising clock edges
`timescale 1ns/1ps
module rxp_link_model (
  input  wire         i_ref_clk,
  output reg          o_valid,
  output reg  [4:0]   o_page,
  output reg  [31:0]  o_map,
  output reg  [23:0]  o_low,
  output reg  [511:0] o_groups
);
  integer g;
  initial
  begin
    o_valid = 1'b0;
    o_page = 5'h1f;
    o_map = 32'hffffffff;
    o_low = {6'd17, 6'd42, 6'd63, 6'd5};
    for (g = 0; g < 64; g = g + 1)
      o_groups[8*g +: 8] = g[7:0] * 8'h1d;
  end
  task load(input [7:0] s);
    for (g = 0; g < 64; g = g + 1)
      o_groups[8*g +: 8] <= s + g[7:0] * 8'h1d;
  endtask
  // page lines flip once the access is over, so a stale page is never reused
  task access(input [4:0] p);
    o_valid <= 1'b1;
    o_page <= p;
    @(posedge i_ref_clk);
    o_valid <= 1'b0;
    o_page <= ~p;
  endtask
endmodule // rxp_link_model

// >>> test/rxp_tb_top.sv
// self-checking bench: bus master tasks, fault, base and probe scenarios
// assumes the partner model feeds the link and probe inputs
`timescale 1ns/1ps
`include "rxp_regs.vh"
module rxp_tb_top;
  reg          i_ref_clk = 0, i_reset_n = 0;
  reg  [31:0]  i_s_axi_awaddr = 0, i_s_axi_wdata = 0, i_s_axi_araddr = 0;
  reg  [3:0]   i_s_axi_wstrb = 0;
  reg          i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  reg          i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire         o_s_axi_rvalid, o_radio_error_interrupt, o_irq, i_xmem_access_valid;
  wire [1:0]   o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0]  o_s_axi_rdata, i_xmem_page_map;
  wire [7:0]   o_probe_port;
  wire [6:0]   o_xmem_base_field;
  wire [4:0]   i_xmem_access_page;
  wire [23:0]  i_probe_low_sources;
  wire [511:0] i_probe_groups;
  int          fails = 0, compares = 0, i;
  logic [31:0] lc [3] = '{32'hffffffff, 32'h83a5c11f, 32'h3f3f3f3f};
  logic [31:0] bc [3] = '{32'hffffffff, 32'h9abc0123, 32'h88888888};

  rxp_top u_dut (.*);
  rxp_link_model u_link (.i_ref_clk(i_ref_clk), .o_valid(i_xmem_access_valid),
    .o_page(i_xmem_access_page), .o_map(i_xmem_page_map),
    .o_low(i_probe_low_sources), .o_groups(i_probe_groups));

  initial forever #2 i_ref_clk = ~i_ref_clk;

  // ==========================================================
  // compare and bus tasks
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic ta, tw, tb, q;
    logic [1:0] r;
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= 4'hf;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    tb = 0;
    q = 0;
    while (!tb)
    begin
      @(negedge i_ref_clk);
      ta = i_s_axi_awvalid && o_s_axi_awready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      tb = o_s_axi_bvalid;
      q = o_s_axi_awready || o_s_axi_wready;
      r = o_s_axi_bresp;
      @(posedge i_ref_clk);
      if (ta) i_s_axi_awvalid <= 1'b0;
      if (tw) i_s_axi_wvalid <= 1'b0;
    end
    i_s_axi_bready <= 1'b0;
    chk({31'h0, q}, 32'h0);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge i_ref_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    tr = 0;
    while (!tr)
    begin
      @(negedge i_ref_clk);
      ta = i_s_axi_arvalid && o_s_axi_arready;
      tr = o_s_axi_rvalid;
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      @(posedge i_ref_clk);
      if (ta) i_s_axi_arvalid <= 1'b0;
    end
    i_s_axi_rready <= 1'b0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  function automatic [7:0] exp_port(input logic [31:0] l, b);
    logic [7:0] w;
    logic [5:0] s;
    for (int k = 0; k < 8; k++)
    begin
      s = k < 4 ? u_link.o_low[6*k +: 6] : l[8*k-32 +: 6];
      w = (k < 4 || l[8*k-25]) ? u_link.o_groups[8*s +: 8] : 8'h00;
      exp_port[k] = w[b[4*k +: 3]] ^ b[4*k+3];
    end
  endfunction
  task conclude;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    rd(`RXP_MISC_ADDR, 32'h4, `RXP_RESP_OKAY);
    rd(`RXP_BASE_ADDR, 32'h0, `RXP_RESP_OKAY);
    rd(`RXP_LSU_ADDR, 32'h0, `RXP_RESP_OKAY);
    rd(`RXP_BSI_ADDR, 32'h0, `RXP_RESP_OKAY);
    rd(32'h40000300, 32'h0, `RXP_RESP_SLVERR);
    wr(32'h40000300, 32'hffffffff, `RXP_RESP_SLVERR);
    @(negedge i_ref_clk);
    chk(o_probe_port, exp_port(0, 0));
    $display("test reset done");
  endtask
  task t_fault;
    @(posedge i_ref_clk);
    u_link.o_map <= 32'hfffffff7;
    u_link.access(5'd4);
    rd(`RXP_MISC_ADDR, 32'h4, `RXP_RESP_OKAY);
    u_link.access(5'd3);
    repeat (2) @(negedge i_ref_clk);
    chk(o_radio_error_interrupt, 1);
    wr(`RXP_MISC_ADDR, 32'h5, `RXP_RESP_OKAY);
    rd(`RXP_MISC_ADDR, 32'h5, `RXP_RESP_OKAY);
    wr(`RXP_MISC_ADDR, 32'h6, `RXP_RESP_OKAY);
    rd(`RXP_MISC_ADDR, 32'h4, `RXP_RESP_OKAY);
    wr(`RXP_MISC_ADDR, 32'h0, `RXP_RESP_OKAY);
    wr(`RXP_IRQ_MASK_ADDR, 32'h1, `RXP_RESP_OKAY);
    u_link.access(5'd3);
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk({o_radio_error_interrupt, o_irq}, 2'b01);
    rd(`RXP_MISC_ADDR, 32'h1, `RXP_RESP_OKAY);
    rd(`RXP_IRQ_STAT_ADDR, 32'h1, `RXP_RESP_OKAY);
    wr(`RXP_IRQ_STAT_ADDR, 32'h1, `RXP_RESP_OKAY);
    wr(`RXP_MISC_ADDR, 32'h4, `RXP_RESP_OKAY);
    @(negedge i_ref_clk);
    chk({o_radio_error_interrupt, o_irq}, 2'b10);
    wr(`RXP_MISC_ADDR, 32'h6, `RXP_RESP_OKAY);
    @(negedge i_ref_clk);
    chk(o_radio_error_interrupt, 0);
    $display("test fault done");
  endtask
  task t_base;
    wr(`RXP_BASE_ADDR, 32'hffffffff, `RXP_RESP_OKAY);
    rd(`RXP_BASE_ADDR, 32'h0001fc00, `RXP_RESP_OKAY);
    @(negedge i_ref_clk);
    chk(o_xmem_base_field, 7'h7f);
    wr(`RXP_BASE_ADDR, 32'hfffed7ff, `RXP_RESP_OKAY);
    rd(`RXP_BASE_ADDR, 32'h0000d400, `RXP_RESP_OKAY);
    @(negedge i_ref_clk);
    chk(o_xmem_base_field, 7'h35);
    $display("test base done");
  endtask
  task t_probe;
    for (i = 0; i < 3; i++)
    begin
      @(posedge i_ref_clk);
      u_link.load(8'h47 * i[7:0] + 8'h01);
      wr(`RXP_LSU_ADDR, lc[i], `RXP_RESP_OKAY);
      wr(`RXP_BSI_ADDR, bc[i], `RXP_RESP_OKAY);
      rd(`RXP_LSU_ADDR, lc[i] & `RXP_LSU_RW_MASK, `RXP_RESP_OKAY);
      rd(`RXP_BSI_ADDR, bc[i], `RXP_RESP_OKAY);
      @(negedge i_ref_clk);
      chk(o_probe_port, exp_port(lc[i], bc[i]));
    end
    $display("test probe done");
  endtask

  initial
  begin
    #(6000 * 4);
    fails++;
    conclude;
  end
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_reset;
    t_fault;
    t_base;
    t_probe;
    conclude;
  end
endmodule // rxp_tb_top
